/* File: rtl/sbra_consts.svh */
// Named constants for the shared bus request arbiter.
`ifndef SBRA_CONSTS_SVH
`define SBRA_CONSTS_SVH
`define SBRA_NODES        6
`define SBRA_ID_W         3
`define SBRA_NO_NODE      3'h0
`define SBRA_ONE_ID       3'h1
`define SBRA_LAST_ID      3'h6
`define SBRA_ALL_IDLE_N   6'h3F
`define SBRA_SEL_W        3
`define SBRA_ADDR_W       32
`define SBRA_DATA_W       48
`define SBRA_MP_SPACE     32'h0008_0000
`define SBRA_MP_LIMIT     32'h003F_FFFF
`define SBRA_REGION_SHIFT 19
`endif

/* File: rtl/sbra_pkg.sv */
// Types shared by the shared bus request arbiter files.
package sbra_pkg;
  typedef enum logic [1:0] {
    SBRA_IDLE_type_s = 2'b00,
    SBRA_SLAVE_s     = 2'b01,
    SBRA_TRANS_s     = 2'b10,
    SBRA_MASTER_s    = 2'b11
  } sbra_state_type;
endpackage : sbra_pkg

/* File: rtl/sbra_pick.sv */
// Priority picker: chooses the winning requester under fixed or rotating priority.
`timescale 1ns/100ps
`include "sbra_consts.svh"
module sbra_pick
  import sbra_pkg::*;
(
  input  wire logic [`SBRA_NODES-1:0] req,
  input  wire logic                   rotate,
  input  wire logic [`SBRA_ID_W-1:0]  last_won,
  output logic      [`SBRA_ID_W-1:0]  winner
);
  ////////////////////////////////////////////////////////////////////////////
  // Fixed: lowest ID wins. Rotating: search starts just after the last winner.
  always_comb begin
    logic [`SBRA_ID_W-1:0] start;
    logic [`SBRA_ID_W-1:0] cand;
    logic [`SBRA_ID_W:0]   sum;
    start  = `SBRA_ONE_ID;
    cand   = `SBRA_NO_NODE;
    sum    = '0;
    winner = `SBRA_NO_NODE;
    if (rotate && last_won != `SBRA_NO_NODE) begin
      start = (last_won == `SBRA_LAST_ID) ? `SBRA_ONE_ID : `SBRA_ID_W'(last_won + `SBRA_ONE_ID);
    end
    for (int i = `SBRA_NODES - 1; i >= 0; i--) begin
      // One spare bit keeps start plus offset from wrapping before the modulo step.
      sum = {1'b0, start} + {1'b0, `SBRA_ID_W'(i)};
      if (sum > {1'b0, `SBRA_LAST_ID}) begin
        sum = sum - {1'b0, `SBRA_LAST_ID};
      end
      cand = sum[`SBRA_ID_W-1:0];
      if (req[cand - `SBRA_ONE_ID]) begin
        winner = cand;
      end
    end
  end
endmodule : sbra_pick

/* File: rtl/sbra_node.sv */
// One node's distributed bus arbiter with multiprocessor-space access decode.
`timescale 1ns/100ps
`include "sbra_consts.svh"
module sbra_node
  import sbra_pkg::*;
(
  input  wire logic                     CORE_CLK,
  input  wire logic                     SYS_RST,
  input  wire logic [`SBRA_ID_W-1:0]    NODE_ID,
  input  wire logic                     PRIORITY_SCHEME_SELECT,
  input  wire logic                     CORE_PRIORITY_ACCESS,
  input  wire logic [`SBRA_NODES-1:0]   BUS_REQUEST_LINE_N_IN,
  output logic      [`SBRA_NODES-1:0]   BUS_REQUEST_LINE_N_OUT,
  output logic      [`SBRA_NODES-1:0]   BUS_REQUEST_LINE_N_OE,
  input  wire logic                     CORE_REQ,
  input  wire logic                     CORE_WRITE,
  input  wire logic [`SBRA_ADDR_W-1:0]  CORE_ADDR,
  input  wire logic                     DMA_REQ,
  input  wire logic                     DMA_WRITE,
  input  wire logic [`SBRA_ADDR_W-1:0]  DMA_ADDR,
  output logic                          CORE_GRANT,
  output logic                          DMA_GRANT,
  output logic                          BUS_MASTER,
  output logic [`SBRA_ID_W-1:0]         CURRENT_MASTER,
  output logic                          EXT_CYCLE,
  output logic                          EXT_WRITE,
  output logic [`SBRA_ADDR_W-1:0]       EXT_ADDR,
  output logic [`SBRA_ID_W-1:0]         EXT_TARGET_ID
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and ID strap capture.
  logic [`SBRA_NODES-1:0] req_meta_n;
  logic [`SBRA_NODES-1:0] req_sync_n;
  logic [`SBRA_ID_W-1:0]  my_id;
  logic                   rotate;
  logic                   core_first;

  // Peers drive these pins on their own timing, so every line counts as asynchronous.
  // Two flops on every request pin before any logic reads it. The price is two cycles
  // before a peer's request is seen here, the same for every node on the bus.
  // The idle level of the lines is high, so reset fills both stages with ones and no
  // false request appears just after reset.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      req_meta_n <= `SBRA_ALL_IDLE_N;
      req_sync_n <= `SBRA_ALL_IDLE_N;
    end else begin
      req_meta_n <= BUS_REQUEST_LINE_N_IN;
      req_sync_n <= req_meta_n;
    end
  end

  // Static strap levels are captured while reset is held.
  // Sampling them only in reset keeps a change on those pins during a run from
  // reshuffling identity or priority while the bus is in use.
  // Outside reset the captured values simply hold.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      my_id      <= NODE_ID;
      rotate     <= PRIORITY_SCHEME_SELECT;
      core_first <= CORE_PRIORITY_ACCESS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration state.
  logic [`SBRA_NODES-1:0] req;
  logic [`SBRA_ID_W-1:0]  winner;
  logic [`SBRA_ID_W-1:0]  master;
  logic [`SBRA_ID_W-1:0]  next_master;
  logic [`SBRA_ID_W-1:0]  last_won;
  logic [`SBRA_ID_W-1:0]  next_last_won;
  sbra_state_type         state;
  sbra_state_type         next_state;
  logic                   want;
  logic                   own_n;
  logic                   next_own_n;

  // Active-high view of the synchronised lines; own line seen directly.
  // The own line comes from the flop that drives it rather than from the synchroniser,
  // so this node sees its own request before its peers see it.
  // An ID of zero names no node, and the line index is always the ID minus one.
  always_comb begin
    req = ~req_sync_n;
    if (my_id != `SBRA_NO_NODE) begin
      req[my_id - `SBRA_ONE_ID]    = ~own_n;
    end
  end

  sbra_pick u_pick (
    .req      (req),
    .rotate   (rotate),
    .last_won (last_won),
    .winner   (winner)
  );

  // Next master: held while its request stays, passed on via one transition cycle.
  always_comb begin
    next_master   = master;
    next_last_won = last_won;
    next_state    = state;
    unique case (state)
      SBRA_IDLE_type_s: begin
        // An idle bus goes straight to the highest-priority requester, with no gap.
        if (winner != `SBRA_NO_NODE) begin
          next_master   = winner;
          next_last_won = winner;
          next_state    = (winner == my_id) ? SBRA_MASTER_s : SBRA_SLAVE_s;
        end
      end
      SBRA_SLAVE_s, SBRA_MASTER_s: begin
        // The master's line going high ends its tenure; with no other requester the bus
        // simply falls idle and the old master loses no cycle.
        if (!req[master - `SBRA_ONE_ID]) begin
          next_master = `SBRA_NO_NODE;
          next_state  = (winner != `SBRA_NO_NODE) ? SBRA_TRANS_s : SBRA_IDLE_type_s;
        end
      end
      SBRA_TRANS_s: begin
        // One overhead cycle, then the highest-priority requester takes over.
        if (winner != `SBRA_NO_NODE) begin
          next_master   = winner;
          next_last_won = winner;
          next_state    = (winner == my_id) ? SBRA_MASTER_s : SBRA_SLAVE_s;
        end else begin
          next_state = SBRA_IDLE_type_s;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requester side: core and DMA share this node's one request line.
  logic sel_core;
  logic next_core_grant;
  logic next_dma_grant;
  logic next_ext_cycle;
  logic next_ext_write;
  logic [`SBRA_ADDR_W-1:0] next_ext_addr;
  logic [`SBRA_ID_W-1:0]   next_ext_target;
  logic [`SBRA_NODES-1:0]  next_oe;
  logic                    mastering;

  // Request, select and drive the granted access onto the bus.
  // Core and DMA share one request line, which stays low while either wants the bus.
  always_comb begin
    want      = CORE_REQ | DMA_REQ;
    next_own_n = ~want;
    // Grants follow the mastership that the next cycle will register, so a grant never
    // lands in a cycle in which this node has already handed the bus back.
    mastering = (next_state == SBRA_MASTER_s) && (next_master == my_id);
    sel_core  = CORE_REQ && (core_first || !DMA_REQ);
    next_core_grant = mastering && sel_core;
    next_dma_grant  = mastering && !sel_core && DMA_REQ;
    next_ext_cycle  = next_core_grant | next_dma_grant;
    next_ext_write  = sel_core ? CORE_WRITE : DMA_WRITE;
    next_ext_addr   = sel_core ? CORE_ADDR : DMA_ADDR;
    next_ext_target = `SBRA_NO_NODE;
    // Multiprocessor space: address bits above the region size name the target node.
    // Addresses outside the window leave the target at zero, which names no node.
    if (next_ext_cycle && next_ext_addr >= `SBRA_MP_SPACE && next_ext_addr <= `SBRA_MP_LIMIT) begin
      next_ext_target = `SBRA_ID_W'(next_ext_addr >> `SBRA_REGION_SHIFT);
    end
    next_oe = '0;
    if (my_id != `SBRA_NO_NODE) begin
      next_oe[my_id - `SBRA_ONE_ID] = want;
    end
  end

  // Register every output except the request-line data, and all arbitration state.
  // Every output of the node comes straight from a flop, here or below, so its timing
  // depends on the clock alone and never on a combinational path.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state                  <= SBRA_IDLE_type_s;
      master                 <= `SBRA_NO_NODE;
      last_won               <= `SBRA_NO_NODE;
      own_n                  <= 1'b1;
      BUS_REQUEST_LINE_N_OE  <= '0;
      CORE_GRANT             <= 1'b0;
      DMA_GRANT              <= 1'b0;
      EXT_CYCLE              <= 1'b0;
      EXT_WRITE              <= 1'b0;
      EXT_ADDR               <= '0;
      EXT_TARGET_ID          <= `SBRA_NO_NODE;
      BUS_MASTER             <= 1'b0;
      CURRENT_MASTER         <= `SBRA_NO_NODE;
    end else begin
      state                  <= next_state;
      master                 <= next_master;
      last_won               <= next_last_won;
      own_n                  <= next_own_n;
      BUS_REQUEST_LINE_N_OE  <= next_oe;
      CORE_GRANT             <= next_core_grant;
      DMA_GRANT              <= next_dma_grant;
      EXT_CYCLE              <= next_ext_cycle;
      EXT_WRITE              <= next_ext_write;
      EXT_ADDR               <= next_ext_addr;
      EXT_TARGET_ID          <= next_ext_target;
      BUS_MASTER             <= (next_state == SBRA_MASTER_s);
      CURRENT_MASTER         <= next_master;
    end
  end

  // Request lines are only ever pulled low; the enable carries the request.
  // Holding the data at zero keeps the pin open-drain, so several nodes may pull a line
  // at once without contention.
  always_ff @(posedge CORE_CLK) begin
    BUS_REQUEST_LINE_N_OUT <= '0;
  end
endmodule : sbra_node

/* File: tb/sbra_node_checker.sv */
// Checker for the ports of one arbiter node.
`timescale 1ns/100ps
`include "sbra_consts.svh"
module sbra_node_checker
  import sbra_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic [2:0]  NODE_ID,
  input wire logic        CORE_PRIORITY_ACCESS,
  input wire logic        CORE_REQ,
  input wire logic        DMA_REQ,
  input wire logic [5:0]  BUS_REQUEST_LINE_N_OE,
  input wire logic        CORE_GRANT,
  input wire logic        DMA_GRANT,
  input wire logic        BUS_MASTER,
  input wire logic [2:0]  CURRENT_MASTER,
  input wire logic        EXT_CYCLE,
  input wire logic [31:0] EXT_ADDR,
  input wire logic [2:0]  EXT_TARGET_ID
);
  // Every check runs on the core clock and sleeps in reset.
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Pins, mastership and handover.
  a_own_line_only: assert property (
    (BUS_REQUEST_LINE_N_OE & ~(6'h01 << (NODE_ID - 3'h1))) == 6'h00) else $error("foreign line");
  a_win_needs_req: assert property (
    $rose(BUS_MASTER) |-> $past(|BUS_REQUEST_LINE_N_OE)) else $error("won unasked");
  a_master_id: assert property (
    BUS_MASTER |-> CURRENT_MASTER == NODE_ID) else $error("master id");
  a_master_holds: assert property (
    BUS_MASTER && CORE_REQ && $past(CORE_REQ) |=> BUS_MASTER) else $error("bus lost");
  a_grant_master: assert property (
    CORE_GRANT || DMA_GRANT |-> BUS_MASTER && EXT_CYCLE) else $error("grant");
  a_core_first: assert property (
    CORE_PRIORITY_ACCESS && $past(CORE_REQ && DMA_REQ && BUS_MASTER) && BUS_MASTER |-> !DMA_GRANT)
    else $error("dma first");
  a_target_decode: assert property (
    EXT_CYCLE |-> EXT_TARGET_ID == ((EXT_ADDR >= `SBRA_MP_SPACE && EXT_ADDR <= `SBRA_MP_LIMIT)
    ? EXT_ADDR[21:19] : 3'h0)) else $error("target");
  a_handover_gap: assert property (
    CURRENT_MASTER != 3'h0 && $past(CURRENT_MASTER) != 3'h0 |-> $stable(CURRENT_MASTER))
    else $error("no gap");
endmodule : sbra_node_checker
bind sbra_node sbra_node_checker chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .NODE_ID(NODE_ID),
  .CORE_PRIORITY_ACCESS(CORE_PRIORITY_ACCESS), .CORE_REQ(CORE_REQ), .DMA_REQ(DMA_REQ),
  .BUS_REQUEST_LINE_N_OE(BUS_REQUEST_LINE_N_OE), .CORE_GRANT(CORE_GRANT), .DMA_GRANT(DMA_GRANT),
  .BUS_MASTER(BUS_MASTER), .CURRENT_MASTER(CURRENT_MASTER), .EXT_CYCLE(EXT_CYCLE),
  .EXT_ADDR(EXT_ADDR), .EXT_TARGET_ID(EXT_TARGET_ID));

/* File: tb/sbra_peer.sv */
// Other nodes on the shared open-drain request lines.
`timescale 1ns/100ps
module sbra_peer (
  input  wire logic [5:0] peer_req,
  input  wire logic [5:0] dut_oe,
  output logic      [5:0] line_n
);
  // Peers hold a line low until told to release; pull-ups idle it high.
  assign line_n = ~(peer_req | dut_oe);
endmodule : sbra_peer

/* File: tb/sbra_node_bench.sv */
// Self-checking bench for one arbiter node.
`timescale 1ns/100ps
module sbra_node_bench;
  logic clk = 0, rst = 1, rot = 0, creq = 0, cw = 0, dreq = 0, core_priority_access = 0;
  logic [5:0] preq = 0, oe, ln, lo;
  logic [31:0] ca = 0, da = 0, ea, seed = 79;
  logic cg, dg, bm, ec, ew;
  logic [2:0] cm, tid;
  int err_total = 0, n_checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////
  sbra_node dut (.CORE_CLK(clk), .SYS_RST(rst), .NODE_ID(3'h3), .PRIORITY_SCHEME_SELECT(rot),
    .CORE_PRIORITY_ACCESS(core_priority_access), .BUS_REQUEST_LINE_N_IN(ln), .BUS_REQUEST_LINE_N_OUT(lo),
    .BUS_REQUEST_LINE_N_OE(oe), .CORE_REQ(creq), .CORE_WRITE(cw), .CORE_ADDR(ca),
    .DMA_REQ(dreq), .DMA_WRITE(da[2]), .DMA_ADDR(da), .CORE_GRANT(cg), .DMA_GRANT(dg),
    .BUS_MASTER(bm), .CURRENT_MASTER(cm), .EXT_CYCLE(ec), .EXT_WRITE(ew), .EXT_ADDR(ea),
    .EXT_TARGET_ID(tid));
  sbra_peer peer (.peer_req(preq), .dut_oe(oe), .line_n(ln));
  // Clock and hang guard.
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function logic [2:0] exp_tid(input logic [31:0] a);
    return (a >= 32'h0008_0000 && a <= 32'h003F_FFFF) ? a[21:19] : 3'h0;
  endfunction : exp_tid
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task wait_cm(input logic [2:0] e);
    for (int i = 0; i < 20 && cm !== e; i++) tick(1);
    chk(cm, e);
  endtask : wait_cm
  task test_done();
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////
  // Reset with the chosen scheme, then alone, core and DMA, and contention.
  task run(input logic r);
    rot = r;
    core_priority_access = r;
    rst = 1;
    tick(5);
    rst = 0;
    repeat (6) begin
      ca = xs();
      if (ca[0]) ca = {10'h000, ca[21:0]};
      cw = ca[1];
      creq = 1;
      wait_cm(3'h3);
      tick(1);
      chk(oe, 6'h04);
      chk(lo, 6'h00);
      chk(bm, 1'b1);
      chk(ea, ca);
      chk(ew, cw);
      chk(tid, exp_tid(ca));
      creq = 0;
      wait_cm(3'h0);
    end
    da = xs();
    dreq = 1;
    creq = 1;
    wait_cm(3'h3);
    tick(1);
    chk(cg, core_priority_access);
    chk(dg, !core_priority_access);
    chk(ea, core_priority_access ? ca : da);
    creq = 0;
    dreq = 0;
    wait_cm(3'h0);
    preq = 6'h02;
    wait_cm(3'h2);
    preq = 6'h03;
    creq = 1;
    tick(8);
    chk(bm, 1'b0);
    chk(cm, 3'h2);
    preq = 6'h01;
    wait_cm(3'h0);
    tick(1);
    chk(cm, r ? 3'h3 : 3'h1);
    preq = 0;
    creq = 0;
    tick(10);
  endtask : run
  initial begin
    run(1'b0);
    run(1'b1);
    test_done();
  end
endmodule : sbra_node_bench
